// File: verilog/pdm_consts.svh
`ifndef PDM_CONSTS_SVH
`define PDM_CONSTS_SVH
`define PDM_OP_STOP        8'h7F
`define PDM_OP_IDLE        8'h6F
`define PDM_RESET_VECTOR   16'h0100
`define PDM_CLKSEL_SLOW    2'h0
`define PDM_CLKSEL_RST     2'h0
`define PDM_STOP_ENTRY_CONTROL_REG_RST     8'h00
`define PDM_CTRL_RST       8'h00
`define PDM_XTAL_DIV       4096
`define PDM_XTAL_DIV_W     12
`define PDM_STAB_BIT       4
`define PDM_STAB_W         8
`define PDM_EXT_IRQ_N      4
`endif

// File: verilog/pdm_pkg.sv
package pdm_pkg;
	typedef enum logic [1:0] {
		PDM_RUN  = 2'h0,
		PDM_IDLE = 2'h1,
		PDM_STOP = 2'h2,
		PDM_STAB = 2'h3
	} pdm_mode_e;
	typedef enum logic [1:0] {
		PDM_SRC_NONE  = 2'h0,
		PDM_SRC_RESET = 2'h1,
		PDM_SRC_IRQ   = 2'h2
	} pdm_src_e;
endpackage

// File: verilog/pdm_stab_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pdm_stab_if;
	logic       start;
	logic       reset_rate;
	logic [1:0] preset_sel;
	logic       done;
	logic [7:0] count;
	modport ctl (output start, output reset_rate, output preset_sel, input done, input count);
	modport tmr (input start, input reset_rate, input preset_sel, output done, output count);
endinterface
`default_nettype wire

// File: verilog/pdm_stab_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "pdm_consts.svh"
module pdm_stab_timer (
	input  wire logic   sys_clk,
	input  wire logic   resetn,
	pdm_stab_if.tmr     st
);
	logic [`PDM_XTAL_DIV_W-1:0] div_r;
	logic [`PDM_STAB_W-1:0]     cnt_r;
	logic                       run_r;
	logic                       tick;
	logic                       done_r;

	always_comb begin
		unique case (st.reset_rate ? 2'h0 : st.preset_sel)
			2'h1:    tick = (div_r[9:0] == 10'h3FF);
			2'h2:    tick = (div_r[6:0] == 7'h7F);
			default: tick = (div_r == 12'hFFF);
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			div_r <= 12'h000;
		else if (st.start)
			div_r <= 12'h000;
		else if (run_r)
			div_r <= div_r + 12'h001;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r  <= 8'h00;
			run_r  <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (st.start) begin
				cnt_r <= 8'h00;
				run_r <= 1'b1;
			end else if (run_r && tick) begin
				cnt_r <= cnt_r + 8'h01;
				if (cnt_r[`PDM_STAB_BIT:0] == 5'h1F) begin // [RQ20]
					run_r  <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end

	assign st.done  = done_r;
	assign st.count = cnt_r;
endmodule
`default_nettype wire

// File: verilog/pdm_wake_sel.sv
`timescale 1ns/10ps
`default_nettype none
`include "pdm_consts.svh"
module pdm_wake_sel (
	input  wire logic [`PDM_EXT_IRQ_N-1:0] ext_irq,
	input  wire logic [`PDM_EXT_IRQ_N-1:0] ext_irq_en,
	input  wire logic                      watch_irq,
	input  wire logic                      watch_on_sub,
	input  wire logic                      any_irq_enabled,
	output logic                           stop_wake,
	output logic                           idle_wake
);
	assign stop_wake = (|(ext_irq & ext_irq_en)) || (watch_irq && watch_on_sub); // [RQ7] [RQ12]
	assign idle_wake = any_irq_enabled; // [RQ17] [RQ18]
endmodule
`default_nettype wire

// File: verilog/pdm_power_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "pdm_consts.svh"
// Functional notes
// [RQ1] stop opcode halts cpu, peripherals and main oscillator
// [RQ2] register file contents held while stopped
// [RQ3] stop left only by reset or qualifying interrupt
// [RQ4] reset wake resets control registers, keeps data registers
// [RQ5] reset wake clears clock select to slowest divider
// [RQ6] after reset stabilization, fetch begins at reset vector
// [RQ7] four external wake interrupts on port 3 end stop
// [RQ8] interrupt wake keeps control registers except stop entry control
// [RQ9] software sets stabilization settings before stop
// [RQ10] interrupt wake keeps clock select bits
// [RQ11] interrupt wake services irq, resumes after stop
// [RQ12] watch timer on sub oscillator may wake from stop
// [RQ13] software writes stop entry control before stop opcode
// [RQ14] idle gates cpu clock only; peripherals keep running
// [RQ15] port directions frozen during idle
// [RQ16] reset ending idle resets controls and selects slowest clock
// [RQ17] masked interrupts keep idle until reset
// [RQ18] enabled interrupt ends idle, clock unchanged, resumes after idle
// [RQ19] reset stabilization count advances at main clock over 4096
// [RQ20] stabilization ends on counter bit 4 overflow
// [RQ21] power mode held in state register
module pdm_power_ctrl (
	input  wire logic                      sys_clk,
	input  wire logic                      resetn,
	input  wire logic                      op_valid,
	input  wire logic [7:0]                op_code,
	input  wire logic [15:0]               op_next_pc,
	input  wire logic                      return_from_interrupt,
	input  wire logic [`PDM_EXT_IRQ_N-1:0] external_wake_irq,
	input  wire logic [`PDM_EXT_IRQ_N-1:0] external_wake_en,
	input  wire logic                      watch_irq,
	input  wire logic                      watch_on_sub,
	input  wire logic                      any_irq_enabled,
	input  wire logic                      stop_ctl_we,
	input  wire logic [7:0]                stop_ctl_wdata,
	input  wire logic                      clk_sel_we,
	input  wire logic [1:0]                clk_sel_wdata,
	input  wire logic [1:0]                stab_preset_sel,
	input  wire logic [7:0]                port_dir_live,
	output logic [1:0]                     power_mode,
	output logic                           cpu_clk_en,
	output logic                           periph_clk_en,
	output logic                           osc_en,
	output logic                           ctrl_regs_reset,
	output logic                           regfile_hold,
	output logic                           irq_service,
	output logic                           pc_load,
	output logic [15:0]                    pc_load_value,
	output logic [7:0]                     stop_entry_control_reg,
	output logic [1:0]                     system_clock_select_reg,
	output logic [7:0]                     port_dir,
	output logic [7:0]                     stabilization_counter
);
	pdm_pkg::pdm_mode_e mode_r;
	pdm_pkg::pdm_src_e  src_r;
	pdm_stab_if         st ();
	logic               stop_wake;
	logic               idle_wake;
	logic               boot_r;
	logic               start_r;
	logic               pc_load_r;
	logic [15:0]        pc_val_r;
	logic [15:0]        resume_pc_r;
	logic               svc_r;
	logic [7:0]         dir_hold_r;

	pdm_wake_sel u_wake (
		.ext_irq         (external_wake_irq),
		.ext_irq_en      (external_wake_en),
		.watch_irq       (watch_irq),
		.watch_on_sub    (watch_on_sub),
		.any_irq_enabled (any_irq_enabled),
		.stop_wake       (stop_wake),
		.idle_wake       (idle_wake)
	);

	pdm_stab_timer u_stab (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.st      (st)
	);

	// a reset always passes through stabilization at fxx/4096
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			boot_r <= 1'b1;
		else
			boot_r <= 1'b0;
	end

	// mode state machine
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode_r  <= pdm_pkg::PDM_STAB; // [RQ3]
			src_r   <= pdm_pkg::PDM_SRC_RESET;
			start_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			if (boot_r) begin
				start_r <= 1'b1; // [RQ19]
			end else begin
				unique case (mode_r)
					pdm_pkg::PDM_RUN: begin
						if (op_valid && op_code == `PDM_OP_STOP)
							mode_r <= pdm_pkg::PDM_STOP; // [RQ1] [RQ21]
						else if (op_valid && op_code == `PDM_OP_IDLE)
							mode_r <= pdm_pkg::PDM_IDLE; // [RQ14]
					end
					pdm_pkg::PDM_IDLE: begin
						if (idle_wake) begin
							mode_r <= pdm_pkg::PDM_RUN; // [RQ18]
							src_r  <= pdm_pkg::PDM_SRC_IRQ;
						end
					end
					pdm_pkg::PDM_STOP: begin
						if (stop_wake) begin
							mode_r  <= pdm_pkg::PDM_STAB; // [RQ3]
							src_r   <= pdm_pkg::PDM_SRC_IRQ;
							start_r <= 1'b1;
						end
					end
					pdm_pkg::PDM_STAB: begin
						if (st.done)
							mode_r <= pdm_pkg::PDM_RUN; // [RQ20]
					end
				endcase
			end
		end
	end

	assign st.start      = start_r;
	assign st.reset_rate = (src_r == pdm_pkg::PDM_SRC_RESET); // [RQ19]
	assign st.preset_sel = stab_preset_sel; // [RQ9]

	// resume address capture at entry
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			resume_pc_r <= 16'h0000;
		else if (mode_r == pdm_pkg::PDM_RUN && op_valid &&
				(op_code == `PDM_OP_STOP || op_code == `PDM_OP_IDLE))
			resume_pc_r <= op_next_pc;
	end

	// fetch redirect and interrupt service request
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pc_load_r <= 1'b0;
			pc_val_r  <= 16'h0000;
			svc_r     <= 1'b0;
		end else begin
			pc_load_r <= 1'b0;
			if (mode_r == pdm_pkg::PDM_STAB && st.done && !boot_r) begin
				if (src_r == pdm_pkg::PDM_SRC_RESET) begin
					pc_load_r <= 1'b1;
					pc_val_r  <= `PDM_RESET_VECTOR; // [RQ6]
				end else begin
					svc_r <= 1'b1; // [RQ11]
				end
			end else if (mode_r == pdm_pkg::PDM_IDLE && idle_wake) begin
				svc_r <= 1'b1; // [RQ18]
			end else if (svc_r && return_from_interrupt) begin
				svc_r     <= 1'b0;
				pc_load_r <= 1'b1;
				pc_val_r  <= resume_pc_r; // [RQ11] [RQ18]
			end
		end
	end

	// stop entry control: written before stop, cleared on interrupt wake
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			stop_entry_control_reg <= `PDM_STOP_ENTRY_CONTROL_REG_RST; // [RQ4] [RQ16]
		else if (mode_r == pdm_pkg::PDM_STOP && stop_wake)
			stop_entry_control_reg <= `PDM_STOP_ENTRY_CONTROL_REG_RST; // [RQ8]
		else if (stop_ctl_we && mode_r == pdm_pkg::PDM_RUN)
			stop_entry_control_reg <= stop_ctl_wdata; // [RQ13]
	end

	// clock divider select: slowest after reset, held across interrupt wake
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			system_clock_select_reg <= `PDM_CLKSEL_RST; // [RQ5] [RQ16]
		else if (clk_sel_we && mode_r == pdm_pkg::PDM_RUN)
			system_clock_select_reg <= clk_sel_wdata; // [RQ10]
	end

	// port direction frozen while idle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			dir_hold_r <= 8'h00;
		else if (mode_r == pdm_pkg::PDM_RUN)
			dir_hold_r <= port_dir_live;
	end

	assign port_dir = (mode_r == pdm_pkg::PDM_IDLE) ? dir_hold_r : port_dir_live; // [RQ15]

	assign power_mode      = mode_r;
	assign cpu_clk_en      = (mode_r == pdm_pkg::PDM_RUN); // [RQ14]
	assign periph_clk_en   = (mode_r == pdm_pkg::PDM_RUN) || (mode_r == pdm_pkg::PDM_IDLE); // [RQ1] [RQ14]
	assign osc_en          = (mode_r != pdm_pkg::PDM_STOP); // [RQ1]
	assign ctrl_regs_reset = boot_r; // [RQ4] [RQ16]
	assign regfile_hold    = (mode_r != pdm_pkg::PDM_RUN); // [RQ2]
	assign irq_service     = svc_r;
	assign pc_load         = pc_load_r;
	assign pc_load_value   = pc_val_r;
	assign stabilization_counter = st.count;
endmodule
`default_nettype wire

// File: bench/pdm_power_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "pdm_consts.svh"
module pdm_power_ctrl_properties (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        op_valid,
	input wire logic [7:0]  op_code,
	input wire logic [3:0]  external_wake_irq,
	input wire logic [3:0]  external_wake_en,
	input wire logic        watch_irq,
	input wire logic        watch_on_sub,
	input wire logic        any_irq_enabled,
	input wire logic [1:0]  power_mode,
	input wire logic        cpu_clk_en,
	input wire logic        periph_clk_en,
	input wire logic        osc_en,
	input wire logic        regfile_hold,
	input wire logic        irq_service,
	input wire logic        pc_load,
	input wire logic [15:0] pc_load_value,
	input wire logic [7:0]  stop_entry_control_reg,
	input wire logic [1:0]  system_clock_select_reg,
	input wire logic [7:0]  port_dir
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	AST_STOP_HALT: assert property (power_mode == pdm_pkg::PDM_STOP |-> !cpu_clk_en && !periph_clk_en && !osc_en)
		else $error("clocks running in stop");
	AST_STOP_ENTRY: assert property (op_valid && op_code == `PDM_OP_STOP && power_mode == pdm_pkg::PDM_RUN
		|=> power_mode == pdm_pkg::PDM_STOP) else $error("stop opcode not taken");
	AST_REGFILE: assert property (power_mode != pdm_pkg::PDM_RUN |-> regfile_hold)
		else $error("register file not held");
	AST_STOP_EXIT: assert property (power_mode == pdm_pkg::PDM_STOP ##1 power_mode != pdm_pkg::PDM_STOP
		|-> ($past(external_wake_irq & external_wake_en) != 4'h0) || $past(watch_irq && watch_on_sub))
		else $error("stop left without wake");
	AST_CLKSEL_KEEP: assert property (power_mode != pdm_pkg::PDM_RUN |=> $stable(system_clock_select_reg))
		else $error("clock select changed");
	AST_IDLE_ENTRY: assert property (op_valid && op_code == `PDM_OP_IDLE && power_mode == pdm_pkg::PDM_RUN
		|=> power_mode == pdm_pkg::PDM_IDLE && !cpu_clk_en && periph_clk_en) else $error("idle entry wrong");
	AST_PORT_FREEZE: assert property (power_mode == pdm_pkg::PDM_IDLE ##1 power_mode == pdm_pkg::PDM_IDLE
		|-> $stable(port_dir)) else $error("port direction moved in idle");
	AST_IDLE_MASKED: assert property (power_mode == pdm_pkg::PDM_IDLE && !any_irq_enabled
		|=> power_mode == pdm_pkg::PDM_IDLE) else $error("idle left while masked");
	AST_STOPCTL_CLR: assert property (power_mode == pdm_pkg::PDM_STOP ##1 power_mode == pdm_pkg::PDM_STAB
		|-> stop_entry_control_reg == 8'h00) else $error("stop control kept");
	AST_VECTOR: assert property (pc_load && !irq_service && $past(power_mode) == pdm_pkg::PDM_STAB
		|-> pc_load_value == `PDM_RESET_VECTOR) else $error("boot fetch address wrong");
	cover property (pc_load && pc_load_value == `PDM_RESET_VECTOR);
	cover property (power_mode == pdm_pkg::PDM_STOP ##1 power_mode == pdm_pkg::PDM_STAB);
	cover property (power_mode == pdm_pkg::PDM_IDLE ##1 power_mode != pdm_pkg::PDM_IDLE);
endmodule
bind pdm_power_ctrl pdm_power_ctrl_properties u_props (.sys_clk, .resetn, .op_valid, .op_code,
	.external_wake_irq, .external_wake_en, .watch_irq, .watch_on_sub, .any_irq_enabled, .power_mode,
	.cpu_clk_en, .periph_clk_en, .osc_en, .regfile_hold, .irq_service, .pc_load, .pc_load_value,
	.stop_entry_control_reg, .system_clock_select_reg, .port_dir);
`default_nettype wire

// File: bench/pdm_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module pdm_cpu_model (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic irq_service,
	output logic     return_from_interrupt
);
	logic [3:0] svc_cnt_r;
	// service routine runs a few cycles, then returns once
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			svc_cnt_r <= 4'h0;
			return_from_interrupt <= 1'b0;
		end else begin
			svc_cnt_r <= irq_service ? (svc_cnt_r == 4'h7 ? svc_cnt_r : svc_cnt_r + 4'h1) : 4'h0;
			return_from_interrupt <= (svc_cnt_r == 4'h6);
		end
	end
endmodule
`default_nettype wire

// File: bench/pdm_power_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pdm_consts.svh"
module pdm_power_ctrl_tb;
	logic        sys_clk = 1'b0, resetn = 1'b0, op_valid = 1'b0, watch_irq = 1'b0, watch_on_sub = 1'b0;
	logic        any_irq_enabled = 1'b0, stop_ctl_we = 1'b0, clk_sel_we = 1'b0, return_from_interrupt;
	logic [7:0]  op_code = 8'h00, port_dir_live = 8'h3C, stop_entry_control_reg, port_dir, stab_cnt;
	logic [15:0] op_next_pc = 16'h0000, pc_load_value;
	logic [3:0]  external_wake_irq = 4'h0, external_wake_en = 4'h0;
	logic [1:0]  clk_sel_wdata = 2'h0, power_mode, system_clock_select_reg;
	logic        cpu_clk_en, periph_clk_en, osc_en, ctrl_regs_reset, regfile_hold, irq_service, pc_load;
	int          miscompares = 0, checked = 0, cyc = 0, n;
	logic [10:0] rows [7] = '{11'h089, 11'h111, 11'h221, 11'h441, 11'h007, 11'h200, 11'h004};
	pdm_power_ctrl u_dut (.sys_clk, .resetn, .op_valid, .op_code, .op_next_pc, .return_from_interrupt,
		.external_wake_irq, .external_wake_en, .watch_irq, .watch_on_sub, .any_irq_enabled, .stop_ctl_we,
		.stop_ctl_wdata(8'h5A), .clk_sel_we, .clk_sel_wdata, .stab_preset_sel(2'h2), .port_dir_live,
		.power_mode, .cpu_clk_en, .periph_clk_en, .osc_en, .ctrl_regs_reset, .regfile_hold, .irq_service,
		.pc_load, .pc_load_value, .stop_entry_control_reg, .system_clock_select_reg, .port_dir,
		.stabilization_counter(stab_cnt));
	pdm_cpu_model u_cpu (.sys_clk, .resetn, .irq_service, .return_from_interrupt);
	initial forever #25 sys_clk = ~sys_clk;
	task automatic step(input int k);
		repeat (k) @(posedge sys_clk);
		#5;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic op(input logic [7:0] c, input logic [15:0] pc);
		op_valid = 1'b1;
		op_code = c;
		op_next_pc = pc;
		step(1);
		op_valid = 1'b0;
	endtask
	task automatic wait_mode(input logic [1:0] m, input int lim);
		for (n = 0; power_mode !== m && n < lim; n++) step(1);
		if (n >= lim) chk("mode wait", m, power_mode);
	endtask
	task automatic wait_pc;
		for (n = 0; pc_load !== 1'b1 && n < 20; n++) step(1);
	endtask
	task automatic complete_run;
		$display("counts: %0d checked, %0d miscompares", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 200000) begin
			miscompares++;
			complete_run;
		end
	end
	initial begin
		step(8);
		chk("reset mode", pdm_pkg::PDM_STAB, power_mode);
		chk("reset ctrl", 16'h1, {cpu_clk_en, ctrl_regs_reset});
		resetn = 1'b1;
		wait_mode(pdm_pkg::PDM_RUN, 140000);
		chk("boot length", 16'h1, n >= 131072 && n <= 131080);
		chk("boot pc", 16'h0100, pc_load_value);
		chk("boot count", 16'h20, stab_cnt);
		chk("boot clk sel", 16'h0, system_clock_select_reg);
		$display("test reset boot done");
		clk_sel_we = 1'b1;
		clk_sel_wdata = 2'h3;
		step(1);
		clk_sel_we = 1'b0;
		for (int r = 0; r < 7; r++) begin
			stop_ctl_we = 1'b1;
			step(1);
			stop_ctl_we = 1'b0;
			chk("stop ctl", 16'h5A, stop_entry_control_reg);
			op(`PDM_OP_STOP, 16'h1230 + 16'(r));
			step(2);
			chk("stop osc", 16'h0, osc_en);
			{external_wake_irq, external_wake_en, watch_irq, watch_on_sub} = rows[r][10:1];
			step(2);
			chk("wake", rows[r][0] ? pdm_pkg::PDM_STAB : pdm_pkg::PDM_STOP, power_mode);
			if (!rows[r][0]) begin
				{external_wake_irq, external_wake_en} = 8'h11;
				step(2);
			end
			chk("stop ctl clr", 16'h0, stop_entry_control_reg);
			chk("clk sel kept", 16'h3, system_clock_select_reg);
			{external_wake_irq, external_wake_en, watch_irq, watch_on_sub} = 10'h000;
			wait_mode(pdm_pkg::PDM_RUN, 6000);
			chk("irq service", 16'h1, irq_service);
			wait_pc;
			chk("stop resume", 16'h1230 + 16'(r), pc_load_value);
		end
		$display("test stop wake table done");
		op(`PDM_OP_IDLE, 16'h2345);
		chk("idle clocks", {12'h0, 1'b0, 1'b1, pdm_pkg::PDM_IDLE}, {cpu_clk_en, periph_clk_en, power_mode});
		port_dir_live = 8'hC3;
		step(20);
		chk("idle dir", 16'h3C, port_dir);
		chk("masked idle", pdm_pkg::PDM_IDLE, power_mode);
		any_irq_enabled = 1'b1;
		wait_mode(pdm_pkg::PDM_RUN, 6000);
		any_irq_enabled = 1'b0;
		chk("idle clk sel", 16'h3, system_clock_select_reg);
		wait_pc;
		chk("idle resume", 16'h2345, pc_load_value);
		chk("run dir", 16'hC3, port_dir);
		$display("test idle done");
		op(`PDM_OP_IDLE, 16'h3000);
		resetn = 1'b0;
		step(1);
		chk("idle reset", 16'h1, {system_clock_select_reg, ctrl_regs_reset});
		resetn = 1'b1;
		step(1);
		chk("release mode", pdm_pkg::PDM_STAB, power_mode);
		chk("release ctrl", 16'h0, {cpu_clk_en, ctrl_regs_reset});
		step(1);
		chk("release count", 16'h0, stab_cnt);
		$display("test idle reset done");
		complete_run;
	end
endmodule
`default_nettype wire
